// *** design/srm_defines.svh ***
// Constants for the SPI status readback multiplexer.
`ifndef SRM_DEFINES_SVH
`define SRM_DEFINES_SVH
`define SRM_WORD_BITS 8
`define SRM_CMD_STATUS 4'h0
`define SRM_SEL_RESET 3'h7
`define SRM_SEL_FAULT 3'h0
`define SRM_SEL_OUTCTL 3'h1
`define SRM_SEL_OCTHR 3'h2
`define SRM_SEL_TIMING 3'h3
`define SRM_SEL_DIRECT 3'h4
`define SRM_SEL_DELAY 3'h5
`define SRM_SEL_PINS 3'h6
`define SRM_SEL_NULL 3'h7
// Synchroniser reset word: link clock low, select and the other pins high.
`define SRM_SYNC_RESET 6'h1f
`define SRM_BIT_OT 6
`define SRM_BIT_OCH 5
`define SRM_BIT_OCL 4
`define SRM_BIT_OL 3
`define SRM_BIT_UV 2
`define SRM_BIT_OV 1
`define SRM_BIT_SUM 0
`endif

// *** design/srm_pkg.sv ***
// Types shared by the status readback multiplexer.
package srm_pkg;
  typedef enum logic [2:0] {
    SRM_IDLE = 3'b001,
    SRM_SHIFT = 3'b010,
    SRM_DONE = 3'b100
  } srm_state_t;
endpackage

// *** design/srm_status_mux.sv ***
// Status word selection, fault flags and serial shift for the switch.
`timescale 1ns/100ps
`default_nettype none
`include "srm_defines.svh"
module srm_status_mux (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic reset_i,
  // Serial link pins.
  input wire logic spi_clk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_din_i,
  output logic spi_dout_o,
  output logic spi_dout_oe_o,
  // Raw fault events, level high while present.
  input wire logic over_temp_i,
  input wire logic overcurrent_high_i,
  input wire logic overcurrent_low_i,
  input wire logic open_load_i,
  input wire logic undervoltage_i,
  input wire logic overvoltage_i,
  input wire logic uv_latch_mode_i,
  // Programmed settings kept by the register engine.
  input wire logic current_sense_enable_i,
  input wire logic serial_on_cmd_i,
  input wire logic [3:0] oc_threshold_i,
  input wire logic [1:0] blanking_time_i,
  input wire logic oc_timeout_active_i,
  input wire logic open_load_active_i,
  input wire logic [3:0] direct_input_control_i,
  input wire logic failsafe_output_state_i,
  input wire logic [2:0] turn_on_delay_setting_i,
  input wire logic watchdog_expired_i,
  input wire logic [1:0] watchdog_period_setting_i,
  input wire logic [1:0] supply_protection_disable_i,
  // Switch-on commands, one-cycle pulses.
  input wire logic switch_on_spi_i,
  input wire logic switch_on_direct_i,
  // Live pin levels.
  input wire logic direct_in_pin_i,
  input wire logic failsafe_input_pin_i,
  input wire logic wake_pin_i,
  // Status outputs.
  output logic fault_status_pin_n_o,
  output logic [7:0] fault_flags_o,
  output logic [3:0] readback_selector_o,
  output logic frame_valid_o,
  output logic [7:0] last_command_o
);

  // ==========================================================
  // Pin synchronisers.
  // Two flops per pin; only the second stage feeds logic.
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic [5:0] sync1_nxt;
  logic [5:0] sync2_nxt;
  // Gather the raw pins into one word for the first stage.
  always_comb begin
    sync1_nxt = {spi_clk_i, spi_cs_n_i, spi_din_i, direct_in_pin_i, failsafe_input_pin_i, wake_pin_i};
    sync2_nxt = sync1_r;
  end
  // Reset values match each pin's idle level, so the edge detectors see no
  // false link clock edge when reset is released.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sync1_r <= `SRM_SYNC_RESET;
      sync2_r <= `SRM_SYNC_RESET;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end
  logic sclk_s;
  logic cs_n_s;
  logic din_s;
  logic [2:0] pins_s;
  assign sclk_s = sync2_r[5];
  assign cs_n_s = sync2_r[4];
  assign din_s = sync2_r[3];
  assign pins_s = sync2_r[2:0];

  // ==========================================================
  // Status word assembly.
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [3:0] sel_r;
  logic [3:0] sel_nxt;
  logic wd_bit_r;
  logic wd_bit_nxt;
  logic [7:0] status_word;

  // Three-bit selector echo sits in bits 6 to 4 for every page but faults.
  always_comb begin
    status_word = 8'h00;
    status_word[7] = wd_bit_r;
    status_word[6:4] = sel_r[2:0];
    case (sel_r[2:0])
      `SRM_SEL_FAULT: status_word[6:0] = flags_r[6:0];
      `SRM_SEL_OUTCTL: status_word[1:0] = {current_sense_enable_i, serial_on_cmd_i};
      `SRM_SEL_OCTHR: status_word[3:0] = oc_threshold_i;
      `SRM_SEL_TIMING: status_word[3:0] = {open_load_active_i, oc_timeout_active_i, blanking_time_i};
      `SRM_SEL_DIRECT: status_word[3:0] = direct_input_control_i;
      `SRM_SEL_DELAY: begin
        status_word[7] = sel_r[3];
        if (!sel_r[3]) begin
          status_word[3:0] = {failsafe_output_state_i, turn_on_delay_setting_i};
        end else begin
          status_word[3:0] = {1'b0, watchdog_expired_i, watchdog_period_setting_i};
        end
      end
      `SRM_SEL_PINS: begin
        status_word[7] = sel_r[3];
        if (!sel_r[3]) begin
          status_word[2:0] = pins_s;
        end else begin
          status_word[1:0] = supply_protection_disable_i;
        end
      end
      `SRM_SEL_NULL: status_word[3:0] = 4'h0;
      default: status_word[3:0] = 4'h0;
    endcase
  end

  // ==========================================================
  // Serial frame engine.
  logic sclk_d_r;
  logic cs_d_r;
  logic sclk_d_nxt;
  logic cs_d_nxt;
  logic [7:0] shift_out_r;
  logic [7:0] shift_out_nxt;
  logic [7:0] shift_in_r;
  logic [7:0] shift_in_nxt;
  logic [2:0] bit_cnt_r;
  logic [2:0] bit_cnt_nxt;
  logic any_bits_r;
  logic any_bits_nxt;
  logic dout_r;
  logic dout_nxt;
  logic oe_r;
  logic oe_nxt;
  logic valid_r;
  logic valid_nxt;
  logic [7:0] cmd_r;
  logic [7:0] cmd_nxt;
  logic read_clear;
  srm_pkg::srm_state_t state_r;
  srm_pkg::srm_state_t state_nxt;

  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  assign cs_fall = cs_d_r && !cs_n_s;
  assign cs_rise = !cs_d_r && cs_n_s;
  assign sclk_rise = !sclk_d_r && sclk_s;
  assign sclk_fall = sclk_d_r && !sclk_s;

  // Bits beyond the first byte pass the incoming data through, as a
  // daisy chain expects, so the out-shifter takes din at each rising clock edge.
  always_comb begin
    sclk_d_nxt = sclk_s;
    cs_d_nxt = cs_n_s;
    state_nxt = state_r;
    shift_out_nxt = shift_out_r;
    shift_in_nxt = shift_in_r;
    bit_cnt_nxt = bit_cnt_r;
    any_bits_nxt = any_bits_r;
    dout_nxt = dout_r;
    oe_nxt = oe_r;
    valid_nxt = 1'b0;
    cmd_nxt = cmd_r;
    sel_nxt = sel_r;
    wd_bit_nxt = wd_bit_r;
    read_clear = 1'b0;
    case (state_r)
      srm_pkg::SRM_IDLE: begin
        oe_nxt = 1'b0;
        if (cs_fall) begin
          shift_out_nxt = status_word;
          dout_nxt = status_word[7];
          oe_nxt = 1'b1;
          bit_cnt_nxt = 3'h0;
          any_bits_nxt = 1'b0;
          read_clear = (sel_r[2:0] == `SRM_SEL_FAULT);
          state_nxt = srm_pkg::SRM_SHIFT;
        end
      end
      srm_pkg::SRM_SHIFT: begin
        if (sclk_rise) begin
          shift_in_nxt = {shift_in_r[6:0], din_s};
          shift_out_nxt = {shift_out_r[6:0], din_s};
          bit_cnt_nxt = bit_cnt_r + 3'h1;
          any_bits_nxt = 1'b1;
        end
        if (sclk_fall) begin
          dout_nxt = shift_out_r[7];
        end
        if (cs_rise) begin
          state_nxt = srm_pkg::SRM_DONE;
        end
      end
      srm_pkg::SRM_DONE: begin
        oe_nxt = 1'b0;
        state_nxt = srm_pkg::SRM_IDLE;
        if (any_bits_r && bit_cnt_r == 3'h0) begin
          valid_nxt = 1'b1;
          cmd_nxt = shift_in_r;
          wd_bit_nxt = shift_in_r[7];
          if (shift_in_r[6:3] == `SRM_CMD_STATUS) begin
            sel_nxt = {shift_in_r[7], shift_in_r[2:0]};
          end
        end
      end
      default: state_nxt = srm_pkg::SRM_IDLE;
    endcase
  end

  // Register the frame engine; every flop runs on every clock.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
      state_r <= srm_pkg::SRM_IDLE;
      shift_out_r <= 8'h00;
      shift_in_r <= 8'h00;
      bit_cnt_r <= 3'h0;
      any_bits_r <= 1'b0;
      dout_r <= 1'b0;
      oe_r <= 1'b0;
      valid_r <= 1'b0;
      cmd_r <= 8'h00;
      sel_r <= {1'b0, `SRM_SEL_RESET};
      wd_bit_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_d_nxt;
      cs_d_r <= cs_d_nxt;
      state_r <= state_nxt;
      shift_out_r <= shift_out_nxt;
      shift_in_r <= shift_in_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      any_bits_r <= any_bits_nxt;
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
      valid_r <= valid_nxt;
      cmd_r <= cmd_nxt;
      sel_r <= sel_nxt;
      wd_bit_r <= wd_bit_nxt;
    end
  end

  // ==========================================================
  // Fault flags and fault pin.
  // The word is captured at select fall, so a flag change during a frame shows in the next one.
  logic fs_r;
  logic fs_nxt;
  logic uv_now;
  logic any_fault;
  // Live flags follow their inputs; OCH, OCL and summary hold until a fault page read, latched UV while uv_latch_mode_i is high.
  always_comb begin
    flags_nxt = flags_r;
    fs_nxt = fs_r;
    uv_now = undervoltage_i || (uv_latch_mode_i && flags_r[`SRM_BIT_UV]);
    flags_nxt[7] = 1'b0;
    flags_nxt[`SRM_BIT_OT] = over_temp_i;
    flags_nxt[`SRM_BIT_OL] = open_load_i;
    flags_nxt[`SRM_BIT_OV] = overvoltage_i;
    flags_nxt[`SRM_BIT_UV] = uv_now;
    // OCH, OCL and summary clear only on a read of the fault page; a new event wins.
    flags_nxt[`SRM_BIT_OCH] = overcurrent_high_i || (flags_r[`SRM_BIT_OCH] && !read_clear);
    flags_nxt[`SRM_BIT_OCL] = overcurrent_low_i || (flags_r[`SRM_BIT_OCL] && !read_clear);
    any_fault = over_temp_i || overcurrent_high_i || overcurrent_low_i || open_load_i || uv_now || overvoltage_i;
    flags_nxt[`SRM_BIT_SUM] = any_fault || (flags_r[`SRM_BIT_SUM] && !read_clear);
    if (any_fault) begin
      fs_nxt = 1'b1;
    end else if (switch_on_spi_i || switch_on_direct_i) begin
      fs_nxt = 1'b0;
    end
  end
  // Register the fault flags and the fault pin state.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      flags_r <= 8'h00;
      fs_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      fs_r <= fs_nxt;
    end
  end

  // ==========================================================
  // Outputs.
  assign spi_dout_o = dout_r;
  assign spi_dout_oe_o = oe_r;
  assign fault_status_pin_n_o = !fs_r;
  assign fault_flags_o = flags_r;
  assign readback_selector_o = sel_r;
  assign frame_valid_o = valid_r;
  assign last_command_o = cmd_r;

endmodule
`default_nettype wire

// *** tb/srm_status_mux_props.sv ***
// Port checker for the status readback multiplexer.
`timescale 1ns/100ps
`default_nettype none
module srm_status_mux_props (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic reset_i,
  // Watched inputs.
  input wire logic spi_cs_n_i,
  input wire logic over_temp_i,
  input wire logic switch_on_spi_i,
  input wire logic switch_on_direct_i,
  // Watched outputs.
  input wire logic spi_dout_oe_o,
  input wire logic fault_status_pin_n_o,
  input wire logic [7:0] fault_flags_o,
  input wire logic [3:0] readback_selector_o,
  input wire logic frame_valid_o
);
  // ==========================================
  // Properties.
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // Reset must hold outputs quiet, so it opts out of the default disable.
  AST_RESET: assert property (disable iff (1'b0) reset_i |=> readback_selector_o == 4'h7
    && !spi_dout_oe_o && fault_status_pin_n_o && fault_flags_o == 8'h00 && !frame_valid_o)
    else $error("Outputs not quiet after reset.");
  AST_OCH_HOLD: assert property ($fell(fault_flags_o[5]) |-> readback_selector_o[2:0] == 3'h0 && !spi_cs_n_i)
    else $error("High overcurrent flag cleared without a fault read.");
  AST_OCL_HOLD: assert property ($fell(fault_flags_o[4]) |-> readback_selector_o[2:0] == 3'h0 && !spi_cs_n_i)
    else $error("Low overcurrent flag cleared without a fault read.");
  AST_SUM_CLR: assert property ($fell(fault_flags_o[0]) |-> readback_selector_o[2:0] == 3'h0 && !spi_cs_n_i)
    else $error("Summary flag cleared without a fault read.");
  AST_OT_FLAG: assert property (over_temp_i |-> ##[1:3] fault_flags_o[6] && fault_flags_o[0])
    else $error("Over-temperature not flagged.");
  AST_FS_SET: assert property (over_temp_i |-> ##[1:3] !fault_status_pin_n_o)
    else $error("Fault pin not asserted.");
  AST_FS_REL: assert property ($rose(fault_status_pin_n_o) |-> $past(switch_on_spi_i)
    || $past(switch_on_direct_i) || $past(switch_on_spi_i, 2) || $past(switch_on_direct_i, 2))
    else $error("Fault pin released without switch-on.");
  AST_OE_ON: assert property ($fell(spi_cs_n_i) |-> ##[2:6] spi_dout_oe_o)
    else $error("Output enable did not follow select fall.");
  AST_VALID_END: assert property (frame_valid_o |-> spi_cs_n_i && !spi_dout_oe_o)
    else $error("Frame accepted while still selected.");
  AST_SEL_KEEP: assert property ($changed(readback_selector_o) |-> frame_valid_o || $past(frame_valid_o))
    else $error("Selector changed without a valid frame.");
endmodule
bind srm_status_mux srm_status_mux_props srm_status_mux_props_i (.clock_i, .reset_i, .spi_cs_n_i, .over_temp_i,
  .switch_on_spi_i, .switch_on_direct_i, .spi_dout_oe_o, .fault_status_pin_n_o, .fault_flags_o,
  .readback_selector_o, .frame_valid_o);
`default_nettype wire

// *** tb/srm_spi_master.sv ***
// Behavioural SPI master driving the status multiplexer link.
`timescale 1ns/100ps
`default_nettype none
module srm_spi_master (
  // Link pins.
  output logic spi_clk_o,
  output logic spi_cs_n_o,
  output logic spi_din_o,
  input wire logic spi_dout_i
);
  // ==========================================
  // Idle link: clock stands low, device deselected.
  initial begin
    spi_clk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_din_o = 1'b0;
  end
  // Sends the low n bits MSB first; returned bits are taken at each rising clock.
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    spi_cs_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      spi_din_o = tx[i];
      #62.5 spi_clk_o = 1'b1;
      rx = {rx[6:0], spi_dout_i};
      #62.5 spi_clk_o = 1'b0;
    end
    #62.5 spi_cs_n_o = 1'b1;
    // A released line must not keep its last value.
    spi_din_o = ~spi_din_o;
    #62.5;
  endtask
endmodule
`default_nettype wire

// *** tb/test_spi_status_readback_mux.sv ***
// Self-checking bench for the status readback multiplexer.
`timescale 1ns/100ps
`default_nettype none
module test_spi_status_readback_mux;
  // ==========================================
  // Stimulus and observation.
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic [22:0] cfg = 23'h2b5a5d;
  logic [2:0] pins = 3'b101;
  logic [6:0] flt = 7'h00;
  logic [1:0] son = 2'b00;
  logic sck, cs_n, din, dout, oe, fs_n, fv;
  logic [7:0] flags, prev, rx, lcmd;
  logic [3:0] sel;
  int mismatches = 0;
  int total_checks = 0;
  logic [7:0] cmds [10] = '{8'h81, 8'h02, 8'h83, 8'h04, 8'h05, 8'h85, 8'h06, 8'h86, 8'h07, 8'h00};
  srm_status_mux srm_status_mux_i (.clock_i(clock_i), .reset_i(reset_i), .spi_clk_i(sck), .spi_cs_n_i(cs_n),
    .spi_din_i(din), .spi_dout_o(dout), .spi_dout_oe_o(oe), .over_temp_i(flt[5]), .overcurrent_high_i(flt[4]),
    .overcurrent_low_i(flt[3]), .open_load_i(flt[2]), .undervoltage_i(flt[1]), .overvoltage_i(flt[0]),
    .uv_latch_mode_i(flt[6]), .current_sense_enable_i(cfg[0]), .serial_on_cmd_i(cfg[1]),
    .oc_threshold_i(cfg[5:2]), .blanking_time_i(cfg[7:6]), .oc_timeout_active_i(cfg[8]),
    .open_load_active_i(cfg[9]), .direct_input_control_i(cfg[13:10]), .failsafe_output_state_i(cfg[14]),
    .turn_on_delay_setting_i(cfg[17:15]), .watchdog_expired_i(cfg[18]), .watchdog_period_setting_i(cfg[20:19]),
    .supply_protection_disable_i(cfg[22:21]), .switch_on_spi_i(son[0]), .switch_on_direct_i(son[1]),
    .direct_in_pin_i(pins[2]), .failsafe_input_pin_i(pins[1]), .wake_pin_i(pins[0]),
    .fault_status_pin_n_o(fs_n), .fault_flags_o(flags), .readback_selector_o(sel), .frame_valid_o(fv),
    .last_command_o(lcmd));
  srm_spi_master srm_spi_master_i (.spi_clk_o(sck), .spi_cs_n_o(cs_n), .spi_din_o(din), .spi_dout_i(dout));
  initial forever #2 clock_i = ~clock_i;
  // Expected word for the page chosen by the previous command c, fault page assumed clean.
  function automatic logic [7:0] expw(input logic [7:0] c);
    case (c[2:0])
      3'h1: expw = {c[7], 5'h04, cfg[0], cfg[1]};
      3'h2: expw = {c[7], 3'h2, cfg[5:2]};
      3'h3: expw = {c[7], 3'h3, cfg[9], cfg[8], cfg[7:6]};
      3'h4: expw = {c[7], 3'h4, cfg[13:10]};
      3'h5: expw = c[7] ? {4'hd, 1'b0, cfg[18], cfg[20:19]} : {4'h5, cfg[14], cfg[17:15]};
      3'h6: expw = c[7] ? {4'he, 2'h0, cfg[22:21]} : {4'h6, 1'b0, pins};
      3'h7: expw = {c[7], 3'h7, 4'h0};
      default: expw = {c[7], 7'h00};
    endcase
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One frame; only whole bytes are compared, bit 3 of the null page is left open.
  task automatic frame(input logic [7:0] tx, input int n, input logic [7:0] e);
    logic [7:0] m;
    m = (prev[2:0] == 3'h7) ? 8'hf7 : 8'hff;
    srm_spi_master_i.xfer(tx, n, rx);
    if (n == 8) begin
      check(rx & m, e & m);
      check(lcmd, tx);
      prev = tx;
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================
  // Main sequence.
  initial begin
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    repeat (3) @(negedge clock_i);
    check({4'h0, sel}, 8'h07);
    prev = 8'h07;
    foreach (cmds[i]) frame(cmds[i], 8, expw(prev));
    frame(8'h01, 7, 8'h00);
    check({4'h0, sel}, 8'h00);
    check(lcmd, 8'h00);
    frame(8'h00, 8, 8'h00);
    @(posedge clock_i) flt <= 7'h3c;
    repeat (2) @(posedge clock_i);
    flt <= 7'h00;
    repeat (5) @(negedge clock_i);
    check(flags, 8'h31);
    frame(8'h00, 8, 8'h31);
    frame(8'h00, 8, 8'h00);
    check({7'h0, fs_n}, 8'h00);
    @(posedge clock_i) son <= 2'b01;
    @(posedge clock_i) son <= 2'b00;
    repeat (3) @(negedge clock_i);
    check({7'h0, fs_n}, 8'h01);
    @(posedge clock_i) flt <= 7'h03;
    repeat (2) @(posedge clock_i);
    flt <= 7'h00;
    repeat (3) @(posedge clock_i);
    son <= 2'b10;
    @(posedge clock_i) son <= 2'b00;
    repeat (3) @(negedge clock_i);
    check({7'h0, fs_n}, 8'h01);
    check(flags, 8'h01);
    @(posedge clock_i) flt <= 7'h42;
    repeat (2) @(posedge clock_i);
    flt <= 7'h40;
    repeat (5) @(negedge clock_i);
    check(flags, 8'h05);
    check({7'h0, fs_n}, 8'h00);
    final_report;
  end
  // Watchdog: the sequence needs about 16 us.
  initial begin
    #100000;
    mismatches++;
    final_report;
  end
endmodule
`default_nettype wire
